// [hdl/urx_map.vh]
`ifndef URX_MAP_VH
`define URX_MAP_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define URX_CTRL_ADDR     12'h000
`define URX_BAUD_ADDR     12'h004
`define URX_STAT_ADDR     12'h008
`define URX_DATA_ADDR     12'h00c

// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define URX_CTRL_EN_BIT   0
`define URX_CTRL_DBL_BIT  1
`define URX_CTRL_PAR_LSB  2
`define URX_CTRL_SIZE_LSB 4
`define URX_CTRL_RST      8'h30
`define URX_BAUD_RST      12'h000

// ------------------------------------------------------------
// parity modes
// ------------------------------------------------------------
`define URX_PAR_EVEN      2'b10
`define URX_PAR_ODD       2'b11

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define URX_STAT_DONE_BIT 7
`define URX_STAT_FRAMING_FAULT_FLAG_BIT 4
`define URX_STAT_OVF_BIT  3
`define URX_STAT_PARITY_FAULT_FLAG_BIT 2

// ------------------------------------------------------------
// sampling: samples per bit and first voting sample
// ------------------------------------------------------------
`define URX_SPB_NORM      5'd16
`define URX_SPB_DBL       5'd8
`define URX_VOTE_NORM     5'd8
`define URX_VOTE_DBL      5'd4
`define URX_MIN_BITS      4'd5
`define URX_MAX_BITS      4'd9

`endif

// [hdl/urx_baud_tick.v]
// ------------------------------------------------------------
// sample tick divider: one pulse every divider+1 clocks
// ------------------------------------------------------------
module urx_baud_tick #(
    parameter DIV_W = 12
) (
    input  wire             clk,
    input  wire             rst,
    input  wire             run,
    input  wire [DIV_W-1:0] divider,
    output reg              tick
);

    reg [DIV_W-1:0] cnt_reg;

    // stopped counter restarts at zero so a fresh enable starts clean
    always @(posedge clk)
    begin
        if (rst || !run)
        begin
            cnt_reg <= {DIV_W{1'b0}};
            tick    <= 1'b0;
        end
        // >= so a smaller divider written mid-count cannot stall the tick
        else if (cnt_reg >= divider)
        begin
            cnt_reg <= {DIV_W{1'b0}};
            tick    <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + {{(DIV_W-1){1'b0}}, 1'b1};
            tick    <= 1'b0;
        end
    end

endmodule // urx_baud_tick

// [hdl/urx_receiver.v]
`include "urx_map.vh"

// Overview of operation
// [R1] with parity on, check received parity bit against data parity
// [R2] even: expected bit one for odd ones count; odd: the reverse
// [R3] receiver disable is immediate, flushes buffer, drops frame in flight
// [R4] software flushes by reading data until done flag clears
// [R5] fault flags travel in the buffer with their frame
// [R6] sample at sixteen per bit, eight per bit in double rate
// [R7] first low sample after idle high is sample one of start
// [R8] normal mode: start valid when two of samples 8,9,10 low
// [R9] double rate: start valid when two of samples 4,5,6 low
// [R10] high majority on start samples: noise, go back to watching
// [R11] bit timing restarts on every accepted start bit
// [R12] each data and parity bit is a majority of centre samples
// [R13] sample bits through first stop bit, never a second stop
// [R14] low first stop bit sets framing fault for that frame
// [R15] new start detectable right after stop vote; later in double rate
// [R16] tolerated rate mismatch follows from vote positions and frame length
// [R17] normal mode, eight bits: keep receiver baud error near two percent
// [R18] double rate, eight bits: keep receiver error within 1.5 percent
// [R19] software picks divider setting giving smallest baud deviation
// [R20] sample counter restarts at each start edge, one step per tick
module urx_receiver #(
    parameter FIFO_DEPTH = 2,
    parameter PTR_W      = 1,
    parameter DIV_W      = 12
) (
    input  wire        MCLK,
    input  wire        SYS_RST,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output wire        PREADY,
    output wire        PSLVERR,
    input  wire        RXD
);

    localparam ST_IDLE  = 3'd0;
    localparam ST_START = 3'd1;
    localparam ST_DATA  = 3'd2;
    localparam ST_PAR   = 3'd3;
    localparam ST_STOP  = 3'd4;
    localparam ST_GAP   = 3'd5;

    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    function maj3;
        input a;
        input b;
        input c;
        begin
            maj3 = (a & b) | (a & c) | (b & c);
        end
    endfunction

    function [3:0] size_bits;
        input [2:0] code;
        begin
            if (code > 3'd4)
                size_bits = `URX_MAX_BITS;
            else
                size_bits = `URX_MIN_BITS + {1'b0, code};
        end
    endfunction

    // bits arrive lsb first at the top of the shifter; move to bit 0
    function [8:0] align;
        input [8:0] sh;
        input [3:0] n;
        begin
            case (n)
                4'd5:    align = {4'h0, sh[8:4]};
                4'd6:    align = {3'h0, sh[8:3]};
                4'd7:    align = {2'h0, sh[8:2]};
                4'd8:    align = {1'h0, sh[8:1]};
                default: align = sh;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    reg  [7:0]       ctrl_reg;
    reg  [DIV_W-1:0] baud_reg;
    reg              rxd_meta_reg;
    reg              rxd_reg;
    reg  [2:0]       state_reg;
    reg  [4:0]       cnt_reg;
    reg  [1:0]       win_reg;
    reg  [3:0]       bit_cnt_reg;
    reg  [8:0]       shift_reg;
    reg              par_acc_reg;
    reg              par_bit_reg;
    reg  [10:0]      fifo_mem [0:FIFO_DEPTH-1];
    reg  [PTR_W-1:0] wr_ptr_reg;
    reg  [PTR_W-1:0] rd_ptr_reg;
    reg  [PTR_W:0]   fill_reg;
    reg              ovf_reg;

    wire             rx_en;
    wire             double_rate_select;
    wire [1:0]       par_mode;
    wire             par_en;
    wire [3:0]       nbits;
    wire [4:0]       spb;
    wire [4:0]       vote_last;
    wire [4:0]       cnt_next;
    wire             tick;
    wire             at_vote;
    wire             vote;
    wire             frame_push;
    wire             framing_fault_flag;
    wire             parity_fault_flag;
    wire             par_expect;
    wire [10:0]      head;
    wire             empty;
    wire             full;
    wire             rx_done_flag;
    wire             apb_acc;
    wire             apb_wr;
    wire             apb_rd;
    wire             mapped;
    wire             pop;
    wire             push_ok;

    // ------------------------------------------------------------
    // configuration decode
    // ------------------------------------------------------------
    assign rx_en              = ctrl_reg[`URX_CTRL_EN_BIT];
    assign double_rate_select = ctrl_reg[`URX_CTRL_DBL_BIT];
    assign par_mode           = ctrl_reg[`URX_CTRL_PAR_LSB+1:`URX_CTRL_PAR_LSB];
    assign par_en             = par_mode[1];
    assign nbits     = size_bits(ctrl_reg[`URX_CTRL_SIZE_LSB+2:`URX_CTRL_SIZE_LSB]);
    assign spb       = double_rate_select ? `URX_SPB_DBL : `URX_SPB_NORM; // [R6]
    // voting window: first, middle, last = first+2 // [R8] [R9] [R16]
    assign vote_last = (double_rate_select ? `URX_VOTE_DBL : `URX_VOTE_NORM)
                       + 5'd2;

    // ------------------------------------------------------------
    // sample tick from the local baud divider
    // ------------------------------------------------------------
    // the divider value and the double rate bit set the rate; the closest
    // achievable rate is software's choice // [R19]
    urx_baud_tick #(
        .DIV_W   (DIV_W)
    ) u_tick (
        .clk     (MCLK),
        .rst     (SYS_RST),
        .run     (rx_en),
        .divider (baud_reg),
        .tick    (tick)
    );

    // ------------------------------------------------------------
    // line synchroniser
    // ------------------------------------------------------------
    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            rxd_meta_reg <= 1'b1;
            rxd_reg      <= 1'b1;
        end
        else
        begin
            rxd_meta_reg <= RXD;
            rxd_reg      <= rxd_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // clock and data recovery
    // ------------------------------------------------------------
    // counter wraps spb -> 1 so every bit keeps the same sample numbers
    assign cnt_next = (cnt_reg == spb) ? 5'd1 : cnt_reg + 5'd1; // [R20]
    assign at_vote  = tick && (cnt_next == vote_last);
    // two stored samples plus the current one form the vote
    assign vote     = maj3(win_reg[1], win_reg[0], rxd_reg); // [R12]

    assign par_expect         = par_acc_reg ^ par_mode[0]; // [R2]
    assign parity_fault_flag  = par_en && (par_bit_reg != par_expect); // [R1]
    assign framing_fault_flag = ~vote; // [R14]
    assign frame_push         = at_vote && (state_reg == ST_STOP);

    always @(posedge MCLK)
    begin
        if (SYS_RST || !rx_en)
        begin
            // disable drops any frame in flight at once // [R3]
            state_reg   <= ST_IDLE;
            cnt_reg     <= 5'd0;
            win_reg     <= 2'b11;
            bit_cnt_reg <= 4'd0;
            shift_reg   <= 9'h000;
            par_acc_reg <= 1'b0;
            par_bit_reg <= 1'b0;
        end
        else if (tick)
        begin
            win_reg <= {win_reg[0], rxd_reg};
            cnt_reg <= cnt_next;
            case (state_reg)
                ST_IDLE:
                begin
                    // falling edge: this low sample is sample one
                    if (win_reg[0] && !rxd_reg)
                    begin
                        cnt_reg   <= 5'd1; // [R7] [R11] [R20]
                        state_reg <= ST_START;
                    end
                end
                ST_START:
                begin
                    if (at_vote)
                    begin
                        if (!vote)
                        begin
                            bit_cnt_reg <= 4'd0; // [R8] [R9]
                            par_acc_reg <= 1'b0;
                            state_reg   <= ST_DATA;
                        end
                        else
                            state_reg <= ST_IDLE; // [R10]
                    end
                end
                ST_DATA:
                begin
                    if (at_vote)
                    begin
                        shift_reg   <= {vote, shift_reg[8:1]}; // [R12]
                        par_acc_reg <= par_acc_reg ^ vote;
                        bit_cnt_reg <= bit_cnt_reg + 4'd1;
                        if (bit_cnt_reg + 4'd1 == nbits)
                            state_reg <= par_en ? ST_PAR : ST_STOP;
                    end
                end
                ST_PAR:
                begin
                    if (at_vote)
                    begin
                        par_bit_reg <= vote; // [R12]
                        state_reg   <= ST_STOP;
                    end
                end
                ST_STOP:
                begin
                    // only the first stop bit is looked at // [R13]
                    // double rate skips one more sample before hunting
                    if (at_vote && double_rate_select)
                        state_reg <= ST_GAP; // [R15]
                    else if (at_vote)
                        state_reg <= ST_IDLE; // [R15]
                end
                ST_GAP:
                    state_reg <= ST_IDLE; // [R15]
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // receive buffer: {parity fault, framing fault, data[8:0]}
    // ------------------------------------------------------------
    assign empty        = (fill_reg == {(PTR_W+1){1'b0}});
    assign full         = (fill_reg == FIFO_DEPTH[PTR_W:0]);
    assign head         = fifo_mem[rd_ptr_reg];
    assign rx_done_flag = ~empty;
    // a frame arriving while full is lost; pop in the same cycle frees room
    assign push_ok      = frame_push && (!full || pop);

    always @(posedge MCLK)
    begin
        if (push_ok)
            fifo_mem[wr_ptr_reg] <= {parity_fault_flag, framing_fault_flag,
                                     align(shift_reg, nbits)}; // [R5]
    end

    always @(posedge MCLK)
    begin
        if (SYS_RST || !rx_en)
        begin
            wr_ptr_reg <= {PTR_W{1'b0}}; // [R3]
            rd_ptr_reg <= {PTR_W{1'b0}};
            fill_reg   <= {(PTR_W+1){1'b0}};
            ovf_reg    <= 1'b0;
        end
        else
        begin
            if (push_ok)
                wr_ptr_reg <= wr_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
            if (pop)
                rd_ptr_reg <= rd_ptr_reg + {{(PTR_W-1){1'b0}}, 1'b1};
            if (push_ok && !pop)
                fill_reg <= fill_reg + {{PTR_W{1'b0}}, 1'b1};
            else if (pop && !push_ok)
                fill_reg <= fill_reg - {{PTR_W{1'b0}}, 1'b1};
            // overflow set wins over the clear by a data read
            if (frame_push && !push_ok)
                ovf_reg <= 1'b1;
            else if (pop)
                ovf_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // apb slave: zero wait states
    // ------------------------------------------------------------
    assign apb_acc = PSEL && PENABLE;
    assign apb_wr  = apb_acc && PWRITE;
    assign apb_rd  = apb_acc && !PWRITE;
    assign mapped  = (PADDR == `URX_CTRL_ADDR) || (PADDR == `URX_BAUD_ADDR) ||
                     (PADDR == `URX_STAT_ADDR) || (PADDR == `URX_DATA_ADDR);
    assign PREADY  = 1'b1;
    assign PSLVERR = apb_acc && !mapped;
    // a data read advances the buffer, so status must be read first
    assign pop     = apb_rd && (PADDR == `URX_DATA_ADDR) && !empty; // [R4] [R5]

    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ctrl_reg <= `URX_CTRL_RST;
            baud_reg <= `URX_BAUD_RST;
        end
        else if (apb_wr)
        begin
            if (PADDR == `URX_CTRL_ADDR)
                ctrl_reg <= {1'b0, PWDATA[6:0]};
            if (PADDR == `URX_BAUD_ADDR)
                baud_reg <= PWDATA[DIV_W-1:0];
        end
    end

    always @*
    begin
        PRDATA = 32'h0000_0000;
        case (PADDR)
            `URX_CTRL_ADDR:
                PRDATA[7:0] = ctrl_reg;
            `URX_BAUD_ADDR:
                PRDATA[DIV_W-1:0] = baud_reg;
            `URX_STAT_ADDR:
            begin
                PRDATA[`URX_STAT_DONE_BIT] = rx_done_flag;
                PRDATA[`URX_STAT_FRAMING_FAULT_FLAG_BIT] = rx_done_flag & head[9];
                PRDATA[`URX_STAT_OVF_BIT]  = ovf_reg;
                PRDATA[`URX_STAT_PARITY_FAULT_FLAG_BIT] = rx_done_flag & head[10];
            end
            `URX_DATA_ADDR:
                PRDATA[8:0] = empty ? 9'h000 : head[8:0];
            default:
                PRDATA = 32'h0000_0000;
        endcase
    end

endmodule // urx_receiver

// [tb/urx_receiver_properties.sv]
module urx_receiver_properties (
    input wire        MCLK,
    input wire        SYS_RST,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    input wire [31:0] PRDATA,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        RXD
);
    timeunit 1ns;
    timeprecision 1ps;

    reg  [6:0]  ctrl_reg;
    reg  [11:0] baud_reg;
    reg         low_seen_reg;
    wire        acc = PSEL && PENABLE;
    wire        rd  = acc && !PWRITE;
    wire        wr  = acc && PWRITE;
    wire        map = PADDR[11:4] == 8'h00 && PADDR[1:0] == 2'b00;
    wire        st  = rd && PADDR == 12'h008;

    // ----
    // shadow of the writable fields, seen from the bus alone
    // ----
    always @(posedge MCLK)
    begin
        if (SYS_RST)
        begin
            ctrl_reg     <= 7'h30;
            baud_reg     <= 12'h000;
            low_seen_reg <= 1'b0;
        end
        else
        begin
            if (wr && PADDR == 12'h000)
                ctrl_reg <= PWDATA[6:0];
            if (wr && PADDR == 12'h004)
                baud_reg <= PWDATA[11:0];
            // a disable empties the buffer, so a fresh frame needs a low
            if (wr && PADDR == 12'h000 && !PWDATA[0])
                low_seen_reg <= 1'b0;
            else if (!RXD)
                low_seen_reg <= 1'b1;
        end
    end

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SYS_RST);

    a_ready_high: assert property ($rose(PENABLE) |-> PREADY)
        else $error("ready low in access");
    a_err_unmapped: assert property (acc && !map |->
            PSLVERR && (PWRITE || PRDATA == 32'h0))
        else $error("unmapped access not refused");
    a_err_mapped: assert property (acc && map |-> !PSLVERR)
        else $error("mapped access refused");
    a_ctrl_read: assert property (rd && PADDR == 12'h000 |->
            PRDATA == {25'h0, ctrl_reg})
        else $error("control readback wrong");
    a_baud_read: assert property (rd && PADDR == 12'h004 |->
            PRDATA == {20'h0, baud_reg})
        else $error("divider readback wrong");
    a_stat_spare: assert property (st |->
            (PRDATA & ~32'h0000009c) == 32'h0)
        else $error("status spare bits set");
    a_data_width: assert property (rd && PADDR == 12'h00c |->
            PRDATA[31:9] == 23'h0)
        else $error("data upper bits set");
    a_off_flush: assert property (st && !ctrl_reg[0] |-> !PRDATA[7])
        else $error("buffer kept while off");
    a_parity_off: assert property (st && !ctrl_reg[3] |-> !PRDATA[2])
        else $error("parity fault without parity");
    a_idle_quiet: assert property (st && !low_seen_reg |-> !PRDATA[7])
        else $error("frame without start edge");

    c_parity: cover property (st && PRDATA[2]);
    c_framing: cover property (st && PRDATA[4]);
    c_overflow: cover property (st && PRDATA[3]);
endmodule // urx_receiver_properties

bind urx_receiver urx_receiver_properties urx_receiver_properties_i (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .RXD(RXD)
);

// [tb/urx_tx_model.sv]
module urx_tx_model (
    input  wire  MCLK,
    output logic RXD
);
    timeunit 1ns;
    timeprecision 1ps;

    initial RXD = 1'b1;

    // each level is held n whole clocks; the caller picks the bit length
    task automatic put(input logic b, input int n);
        @(posedge MCLK);
        RXD <= b;
        repeat (n - 1) @(posedge MCLK);
    endtask

    task automatic send(input logic [8:0] d, input int nb,
                        input logic [1:0] par, input logic bp,
                        input logic bs, input int bc);
        logic p;
        int   i;
        p = ^(d & ((9'h1 << nb) - 9'h1)) ^ par[0] ^ bp;
        put(1'b0, bc);
        for (i = 0; i < nb; i++)
            put(d[i], bc);
        if (par[1])
            put(p, bc);
        put(!bs, bc);
        if (bs)
            put(1'b1, bc);
    endtask
endmodule // urx_tx_model

// [tb/testbench.sv]
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int N = 11;
    logic        mclk    = 1'b0;
    logic        sys_rst = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire         rxd;
    logic [31:0] exp_q[$];
    logic [31:0] seed    = 32'd96646;
    logic [8:0]  dv[3];
    int          fail_count   = 0;
    int          total_checks = 0;
    logic [6:0]  ctl_t[N] = '{7'h31, 7'h39, 7'h3d, 7'h39, 7'h09, 7'h4d,
                              7'h3b, 7'h31, 7'h31, 7'h31, 7'h3f};
    int          dev_t[N] = '{0, 0, 0, 0, 0, 0, 0, 0, -1, 1, 0};
    logic [N-1:0] bp_t = 11'b100_0000_1100;
    logic [N-1:0] bs_t = 11'b000_1000_0000;

    urx_receiver urx_receiver_i (
        .MCLK(mclk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RXD(rxd)
    );
    urx_tx_model urx_tx_model_i (.MCLK(mclk), .RXD(rxd));

    initial forever #4 mclk = ~mclk;

    // ----
    // helpers
    // ----
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic check(input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("BAD %0t exp %h got %h", $time, e, g);
        end
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d);
        psel   <= 1'b1;
        paddr  <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1)
            @(posedge mclk);
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        apb(a, 1'b0, 32'h0);
    endtask

    // status is read before data, since a data read pops the entry
    task automatic frame(input logic [6:0] c, input logic bp,
                         input logic bs, input int bc);
        int         nb;
        logic [8:0] d;
        nb = (c[6:4] > 3'd4) ? 9 : c[6:4] + 5;
        d  = rnd() & ((32'h1 << nb) - 1);
        urx_tx_model_i.send(d, nb, c[3:2], bp, bs, bc);
        repeat (bc) @(posedge mclk);
        rd(12'h008, {24'h0, 1'b1, 2'b0, bs, 1'b0, bp && c[3], 2'b0});
        rd(12'h00c, {23'h0, d});
        rd(12'h008, 32'h0);
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    always @(posedge mclk)
        if (psel && penable && pready && !pwrite)
            check(exp_q.pop_front(), prdata);

    initial
    begin
        repeat (50000) @(posedge mclk);
        fail_count++;
        print_verdict();
    end

    // ----
    // main sequence
    // ----
    initial
    begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        rd(12'h000, 32'h30);
        rd(12'h004, 32'h0);
        rd(12'h008, 32'h0);
        rd(12'h00c, 32'h0);
        rd(12'h010, 32'h0);
        apb(12'h004, 1'b1, 32'h1);
        for (int i = 0; i < N; i++)
        begin
            apb(12'h000, 1'b1, {25'h0, ctl_t[i]});
            frame(ctl_t[i], bp_t[i], bs_t[i],
                  (ctl_t[i][1] ? 16 : 32) + dev_t[i]);
        end
        // slower ticks give the double rate bit a finer length step
        apb(12'h004, 1'b1, 32'h3);
        apb(12'h000, 1'b1, 32'h33);
        frame(7'h33, 1'b0, 1'b0, 31);
        frame(7'h33, 1'b0, 1'b0, 33);
        apb(12'h004, 1'b1, 32'h1);
        apb(12'h000, 1'b1, 32'h31);
        urx_tx_model_i.put(1'b0, 12);
        urx_tx_model_i.put(1'b1, 40);
        frame(7'h31, 1'b0, 1'b0, 32);
        for (int i = 0; i < 3; i++)
        begin
            dv[i] = rnd() & 9'h0ff;
            urx_tx_model_i.send(dv[i], 8, 2'b00, 1'b0, 1'b0, 32);
        end
        repeat (32) @(posedge mclk);
        rd(12'h008, 32'h88);
        rd(12'h00c, {24'h0, dv[0][7:0]});
        rd(12'h008, 32'h80);
        rd(12'h00c, {24'h0, dv[1][7:0]});
        rd(12'h008, 32'h0);
        urx_tx_model_i.send(9'h05a, 8, 2'b00, 1'b0, 1'b0, 32);
        fork
            urx_tx_model_i.send(9'h0a5, 8, 2'b00, 1'b0, 1'b0, 32);
            begin
                repeat (100) @(posedge mclk);
                apb(12'h000, 1'b1, 32'h30);
            end
        join
        rd(12'h008, 32'h0);
        apb(12'h000, 1'b1, 32'h31);
        repeat (40) @(posedge mclk);
        rd(12'h008, 32'h0);
        print_verdict();
    end
endmodule // testbench
